// file: inc/lcis_pkg.sv
// Package for the per-channel event flag block of the line interface.
// Assumes a 20 MHz register clock and AXI4-Lite software access.
package lcis_pkg;

  // ************************************************************
  // Channel layout
  // ************************************************************
  localparam int          NUM_CH     = 22;     // 21 line channels plus one
  localparam int          ADDR_W     = 11;
  localparam int          SLOT_LSB   = 6;      // Channels spaced by 40H
  localparam int          SLOT_W     = 5;
  localparam int          LAST_SLOT  = 20;     // Highest line channel slot
  localparam logic [4:0]  TOP_SLOT   = 5'h1F;  // Extra channel at top address
  localparam logic [4:0]  TOP_INDEX  = 5'h15;  // Array index of extra channel

  // ************************************************************
  // Register offsets inside a channel slot
  // ************************************************************
  localparam logic [5:0]  OFS_FLAGS  = 6'h20;
  localparam logic [5:0]  OFS_EDGE   = 6'h30;
  localparam logic [5:0]  OFS_MASK   = 6'h34;
  localparam logic [5:0]  OFS_STATE  = 6'h38;

  // ************************************************************
  // Field positions and write masks
  // ************************************************************
  localparam int          BIT_AMP    = 7;
  localparam int          BIT_TXJ    = 6;
  localparam int          BIT_RXJ    = 5;
  localparam int          BIT_OC     = 4;
  localparam int          BIT_CLK    = 3;
  localparam int          BIT_TXL    = 2;
  localparam int          BIT_SYS    = 1;
  localparam int          BIT_LINE   = 0;
  localparam logic [7:0]  EDGE_WMASK = 8'h1E;  // Only four select bits exist
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DEC   = 2'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          CLK_GAP_NS    = 2000; // No clock edge this long = absent
  localparam int          CLK_GAP_CYC   = (CLK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    REG_FLAGS = 2'h0,
    REG_EDGE  = 2'h1,
    REG_MASK  = 2'h3,
    REG_STATE = 2'h2
  } lcis_reg_t;

  typedef struct packed {
    logic       hit;
    logic [4:0] ch;
    lcis_reg_t  sel;
  } lcis_dec_t;

  // Per-channel sources from the line logic, same clock
  typedef struct packed {
    logic amplitude_overflow;   // One-cycle event pulse
    logic tx_jitter_fifo_err;   // One-cycle event pulse
    logic rx_jitter_fifo_err;   // One-cycle event pulse
    logic overcurrent_state;    // Level
    logic tx_loss_state;        // Level
    logic system_loss_state;    // Level
    logic line_loss_state;      // Level
  } lcis_chan_in_t;

endpackage

// file: rtl/lcis_event_flags.sv
// Per-channel sticky event flags with edge select, mask and one interrupt.
// Assumes an AXI4-Lite master and line logic on the same 20 MHz clock;
// the channel transmit clocks arrive asynchronously on pins.
//
// Notes on behaviour
// - Amplitude overflow sets flag bit 7
// - Transmit jitter FIFO error sets bit 6
// - Receive jitter FIFO error sets bit 5
// - Writing one clears that flag bit
// - Overcurrent bit 4: rise, or both edges
// - Clock absent bit 3: rise, or both edges
// - Transmit loss bit 2: rise, or both edges
// - System loss bit 1 uses shared select
// - Line loss bit 0 uses shared select
// - Select bit 1 governs both loss flags
// - Interrupt high while any unmasked flag set
// - Flags read/write, reset to zero
// - Four registers per channel, slots 40H apart
// - Clock absent state reads one while missing
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module lcis_event_flags #(
  parameter int NCH     = lcis_pkg::NUM_CH,
  parameter int GAP_CYC = lcis_pkg::CLK_GAP_CYC
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [lcis_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [lcis_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire lcis_pkg::lcis_chan_in_t [NCH-1:0] chan_in,
  input  wire logic [NCH-1:0]                channel_transmit_clock,
  output logic                               irq
);

  localparam int CW = $clog2(GAP_CYC + 1);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [NCH-1:0][7:0]    flag;
    logic [NCH-1:0][7:0]    mask;
    logic [NCH-1:0][7:0]    esel;
    logic [NCH-1:0][4:0]    prev;
    logic [NCH-1:0]         ck_s1;
    logic [NCH-1:0]         ck_s2;
    logic [NCH-1:0]         ck_prev;
    logic [NCH-1:0][CW-1:0] gap;
    logic [NCH-1:0]         absent;
    logic [lcis_pkg::ADDR_W-1:0] awaddr;
    logic                   aw_got;
    logic [7:0]             wdata;
    logic                   wlane;
    logic                   w_got;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   irq;
  } lcis_state_t;

  lcis_state_t         q;
  lcis_state_t         d;
  logic [NCH-1:0][7:0] clr_v;
  logic [NCH-1:0][7:0] set_v;
  logic                wr_fire;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Address to channel and register; misaligned or gaps do not hit
  function automatic lcis_pkg::lcis_dec_t decode(input logic [lcis_pkg::ADDR_W-1:0] a);
    lcis_pkg::lcis_dec_t r;
    logic [4:0]          slot;
    logic [5:0]          ofs;
    r    = '0;
    slot = a[lcis_pkg::SLOT_LSB +: lcis_pkg::SLOT_W];
    ofs  = a[lcis_pkg::SLOT_LSB-1:0];
    r.ch = (slot == lcis_pkg::TOP_SLOT) ? lcis_pkg::TOP_INDEX : slot;
    r.hit = (int'(slot) <= lcis_pkg::LAST_SLOT) || (slot == lcis_pkg::TOP_SLOT);
    case (ofs)
      lcis_pkg::OFS_FLAGS: r.sel = lcis_pkg::REG_FLAGS;
      lcis_pkg::OFS_EDGE:  r.sel = lcis_pkg::REG_EDGE;
      lcis_pkg::OFS_MASK:  r.sel = lcis_pkg::REG_MASK;
      lcis_pkg::OFS_STATE: r.sel = lcis_pkg::REG_STATE;
      default:             r.hit = 1'b0;
    endcase
    return r;
  endfunction

  // Channel source levels in flag bit order 4..0
  function automatic logic [4:0] levels(input lcis_pkg::lcis_chan_in_t ci, input logic absent);
    return {ci.overcurrent_state, absent, ci.tx_loss_state,
            ci.system_loss_state, ci.line_loss_state};
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  // Bus handshakes first, then per-channel flag update
  always_comb begin
    lcis_pkg::lcis_dec_t wd;
    lcis_pkg::lcis_dec_t rd;
    logic [4:0]          cur;
    logic [4:0]          sel;
    logic [4:0]          hit;
    logic                any;
    wd      = decode(q.awaddr);
    rd      = decode(s_axi_araddr);
    cur     = '0;
    sel     = '0;
    hit     = '0;
    any     = 1'b0;
    d       = q;
    clr_v   = '0;
    set_v   = '0;
    wr_fire = q.aw_got && q.w_got && !q.bvalid;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && q.awready) begin
      d.awaddr = s_axi_awaddr;
      d.aw_got = 1'b1;
    end
    if (s_axi_wvalid && q.wready) begin
      d.wdata = s_axi_wdata[7:0];
      d.wlane = s_axi_wstrb[0];
      d.w_got = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = wd.hit ? lcis_pkg::RESP_OKAY : lcis_pkg::RESP_DEC;
      if (wd.hit && q.wlane) begin
        case (wd.sel)
          lcis_pkg::REG_FLAGS: clr_v[wd.ch] = q.wdata;
          lcis_pkg::REG_EDGE:  d.esel[wd.ch] = q.wdata & lcis_pkg::EDGE_WMASK;
          lcis_pkg::REG_MASK:  d.mask[wd.ch] = q.wdata;
          default: ;                                     // State is read only
        endcase
      end
    end

    // Read answered one cycle after the address is taken
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = rd.hit ? lcis_pkg::RESP_OKAY : lcis_pkg::RESP_DEC;
      d.rdata  = '0;
      if (rd.hit) begin
        case (rd.sel)
          lcis_pkg::REG_FLAGS: d.rdata[7:0] = q.flag[rd.ch];
          lcis_pkg::REG_EDGE:  d.rdata[7:0] = q.esel[rd.ch];
          lcis_pkg::REG_MASK:  d.rdata[7:0] = q.mask[rd.ch];
          default:             d.rdata[4:0] = levels(chan_in[rd.ch], q.absent[rd.ch]);
        endcase
      end
    end

    // Per channel: clock watch, edge capture, sticky flags
    for (int c = 0; c < NCH; c++) begin
      d.ck_s1[c]   = channel_transmit_clock[c];
      d.ck_s2[c]   = q.ck_s1[c];
      d.ck_prev[c] = q.ck_s2[c];
      // Any rising clock edge restarts the gap count
      if (q.ck_s2[c] && !q.ck_prev[c]) begin
        d.gap[c]    = '0;
        d.absent[c] = 1'b0;
      end else if (q.gap[c] == CW'(GAP_CYC - 1)) begin
        d.absent[c] = 1'b1;
      end else begin
        d.gap[c] = q.gap[c] + 1'b1;
      end

      // Both loss flags share select bit 1
      cur = levels(chan_in[c], q.absent[c]);
      sel = {q.esel[c][lcis_pkg::BIT_OC], q.esel[c][lcis_pkg::BIT_CLK],
             q.esel[c][lcis_pkg::BIT_TXL], q.esel[c][lcis_pkg::BIT_SYS],
             q.esel[c][lcis_pkg::BIT_SYS]};
      hit = (cur & ~q.prev[c]) | (sel & ~cur & q.prev[c]);
      d.prev[c] = cur;
      set_v[c] = {chan_in[c].amplitude_overflow,
                  chan_in[c].tx_jitter_fifo_err,
                  chan_in[c].rx_jitter_fifo_err,
                  hit};
      // Set wins over a clear in the same cycle
      d.flag[c] = (q.flag[c] & ~clr_v[c]) | set_v[c];
      any = any | (|(d.flag[c] & ~d.mask[c]));
    end

    d.irq     = any;
    d.awready = !d.aw_got;
    d.wready  = !d.w_got;
    d.arready = !d.rvalid;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Everything clears on reset, so flags start at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign irq           = q.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  localparam logic [lcis_pkg::ADDR_W-1:0] TOP_FLAGS_ADDR = {lcis_pkg::TOP_SLOT,
                                                            lcis_pkg::OFS_FLAGS};

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_amp_flag_set: assert property (chan_in[0].amplitude_overflow |=>
    q.flag[0][lcis_pkg::BIT_AMP]) else $error("amplitude flag not set");
  a_txj_flag_set: assert property (chan_in[0].tx_jitter_fifo_err |=>
    q.flag[0][lcis_pkg::BIT_TXJ]) else $error("tx fifo flag not set");
  a_rxj_flag_set: assert property (chan_in[0].rx_jitter_fifo_err |=>
    q.flag[0][lcis_pkg::BIT_RXJ]) else $error("rx fifo flag not set");
  a_one_clears_flag: assert property (clr_v[0][lcis_pkg::BIT_RXJ] &&
    !set_v[0][lcis_pkg::BIT_RXJ] |=> !q.flag[0][lcis_pkg::BIT_RXJ])
    else $error("write one did not clear");
  a_oc_rise_sets: assert property ($rose(chan_in[0].overcurrent_state) |=>
    q.flag[0][lcis_pkg::BIT_OC]) else $error("overcurrent rise missed");
  a_oc_fall_any: assert property ($fell(chan_in[0].overcurrent_state) &&
    q.esel[0][lcis_pkg::BIT_OC] |=> q.flag[0][lcis_pkg::BIT_OC])
    else $error("overcurrent fall missed");
  a_clk_absent_sets: assert property ($rose(q.absent[0]) |=>
    q.flag[0][lcis_pkg::BIT_CLK]) else $error("clock absent flag missed");
  a_txl_rise_sets: assert property ($rose(chan_in[0].tx_loss_state) |=>
    q.flag[0][lcis_pkg::BIT_TXL]) else $error("tx loss flag missed");
  a_sys_fall_shared: assert property ($fell(chan_in[0].system_loss_state) &&
    q.esel[0][lcis_pkg::BIT_SYS] |=> q.flag[0][lcis_pkg::BIT_SYS])
    else $error("system loss fall missed");
  a_line_fall_shared: assert property ($fell(chan_in[0].line_loss_state) &&
    q.esel[0][lcis_pkg::BIT_SYS] |=> q.flag[0][lcis_pkg::BIT_LINE])
    else $error("line loss fall missed");
  a_los_rise_only: assert property ($fell(chan_in[0].line_loss_state) &&
    !q.esel[0][lcis_pkg::BIT_SYS] && !q.flag[0][lcis_pkg::BIT_LINE] |=>
    !q.flag[0][lcis_pkg::BIT_LINE]) else $error("fall caught in rise mode");
  a_irq_level: assert property (irq == (|(q.flag & ~q.mask)))
    else $error("interrupt disagrees with flags");
  a_top_flags_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == TOP_FLAGS_ADDR |=> s_axi_rvalid &&
    s_axi_rdata[7:0] == $past(q.flag[lcis_pkg::TOP_INDEX]))
    else $error("top channel flags read wrong");
  a_clk_gap_absent: assert property (!q.absent[0] && q.gap[0] == CW'(GAP_CYC - 1) &&
    !(q.ck_s2[0] && !q.ck_prev[0]) |=> q.absent[0])
    else $error("clock absence not reported");
  a_flag_sticky: assert property (q.flag[0][lcis_pkg::BIT_AMP] &&
    !clr_v[0][lcis_pkg::BIT_AMP] |=> q.flag[0][lcis_pkg::BIT_AMP])
    else $error("flag dropped without clear");
  a_write_answer: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  c_fall_any_edge: cover property ($fell(chan_in[0].tx_loss_state) &&
    q.esel[0][lcis_pkg::BIT_TXL] ##1 q.flag[0][lcis_pkg::BIT_TXL]);
  c_irq_rise: cover property ($rose(irq));
  c_clear_flag: cover property (q.flag[0] != '0 ##1 wr_fire ##1 q.flag[0] == '0);
  c_set_beats_clear: cover property (clr_v[0] != '0 && (set_v[0] & clr_v[0]) != '0);

endmodule

// file: dv/lcis_txclk_src.sv
// Model of the per-channel transmit clocks that feed the event flag block.
// Assumes the bench starts and stops each channel clock through run.
`timescale 1ns/1ps
module lcis_txclk_src #(
  parameter int NCH  = 22,
  parameter real HALF = 60.5
) (
  input  wire logic [NCH-1:0] run,
  output logic      [NCH-1:0] tclk
);
  // ************************************************************
  // Clock generation
  // ************************************************************
  // Period 121 ns, slower than half the 50 ns register clock so the
  // synchroniser sees every edge without aliasing; unrelated in phase;
  // a stopped channel parks low, so the block sees no edges at all
  initial tclk = '0;
  always begin
    #(HALF);
    tclk = run & ~tclk;
  end
endmodule

// file: dv/lcis_event_flags_bench.sv
// Self-checking bench for the per-channel event flag block.
// Assumes the package, the design and the transmit clock source model.
`timescale 1ns/1ps
module lcis_event_flags_bench;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int NCH  = lcis_pkg::NUM_CH;
  localparam int WAIT = 20; // Gap of 4 cycles plus sync, with margin
  logic                            aclk    = 1'b0;
  logic                            aresetn = 1'b0;
  logic [10:0]                     awaddr  = 11'h000;
  logic [10:0]                     araddr  = 11'h000;
  logic [31:0]                     wdata   = 32'h00000000;
  logic [3:0]                      wstrb   = 4'hF;
  logic                            awvalid = 1'b0;
  logic                            wvalid  = 1'b0;
  logic                            bready  = 1'b0;
  logic                            arvalid = 1'b0;
  logic                            rready  = 1'b0;
  logic                            awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]                      bresp, rresp, r, wresp;
  logic [31:0]                     rdata, d;
  lcis_pkg::lcis_chan_in_t [NCH-1:0] cin = '0;
  logic [NCH-1:0]                  run = '1;
  logic [NCH-1:0]                  tclk;
  int                              bad_count = 0;
  int                              n_tests   = 0;
  int                              cyc       = 0;
  int                              lv [4] = '{3, 2, 1, 0}; // Level source bits
  int                              fl [4] = '{4, 2, 1, 0}; // Their flag bits
  int                              es [4] = '{4, 2, 1, 1}; // Their select bits

  // Register clock, 50 ns
  always #25 aclk = ~aclk;

  lcis_event_flags #(.NCH(NCH), .GAP_CYC(4)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chan_in(cin),
    .channel_transmit_clock(tclk), .irq(irq)
  );

  lcis_txclk_src #(.NCH(NCH)) far_clk (.run(run), .tclk(tclk));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Channel slot address; the extra channel sits in the top slot
  function automatic logic [10:0] ad(input int ch, input logic [5:0] ofs);
    logic [4:0] slot;
    slot = (ch == 21) ? 5'h1F : 5'(ch);
    return {slot, ofs};
  endfunction

  // Address and data offered together, each released when taken
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    wresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [10:0] a, output logic [31:0] q, output logic [1:0] s);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    q = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [10:0] a, input logic [7:0] exp);
    logic [31:0] q;
    logic [1:0]  s;
    rd(a, q, s);
    chk(q, {24'h000000, exp});
  endtask

  // One source bit changed just after an edge
  task automatic drive(input int ch, input int i, input logic v);
    @(posedge aclk);
    cin[ch][i] <= v;
  endtask

  // ************************************************************
  // Timeout and main sequence
  // ************************************************************
  // Whole run needs well under 5000 cycles; a hang ends here
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(ad(0, lcis_pkg::OFS_FLAGS), 8'h00);
    rd_chk(ad(21, lcis_pkg::OFS_FLAGS), 8'h00);
    chk({31'h0, irq}, 32'h0);
    // Pulse events: sticky, write zero ignored, write one clears
    for (int i = 4; i <= 6; i++) begin
      drive(0, i, 1'b1);
      drive(0, i, 1'b0);
      rd_chk(11'h020, 8'h01 << (i + 1));
      chk({31'h0, irq}, 32'h1);
      wr(11'h020, 8'h00);
      chk({30'h0, wresp}, {30'h0, lcis_pkg::RESP_OKAY});
      rd_chk(11'h020, 8'h01 << (i + 1));
      wr(11'h020, 8'h01 << (i + 1));
      rd_chk(11'h020, 8'h00);
      chk({31'h0, irq}, 32'h0);
    end
    // Level sources: rise only, then both edges via the select bit
    for (int k = 0; k < 4; k++) begin
      drive(1, lv[k], 1'b1);
      rd_chk(11'h060, 8'h01 << fl[k]);
      wr(11'h060, 8'h01 << fl[k]);
      drive(1, lv[k], 1'b0);
      rd_chk(11'h060, 8'h00);
      wr(ad(1, lcis_pkg::OFS_EDGE), 8'h01 << es[k]);
      drive(1, lv[k], 1'b1);
      wr(11'h060, 8'h01 << fl[k]);
      drive(1, lv[k], 1'b0);
      rd_chk(11'h060, 8'h01 << fl[k]);
      wr(11'h060, 8'h01 << fl[k]);
      wr(ad(1, lcis_pkg::OFS_EDGE), 8'h00);
    end
    // Transmit clock stops and returns on channel slot 2
    run[2] <= 1'b0;
    repeat (WAIT) @(posedge aclk);
    rd_chk(ad(2, lcis_pkg::OFS_STATE), 8'h08);
    rd_chk(11'h0A0, 8'h08);
    wr(11'h0A0, 8'h08);
    run[2] <= 1'b1;
    repeat (WAIT) @(posedge aclk);
    rd_chk(ad(2, lcis_pkg::OFS_STATE), 8'h00);
    rd_chk(11'h0A0, 8'h00);
    wr(ad(2, lcis_pkg::OFS_EDGE), 8'h08);
    run[2] <= 1'b0;
    repeat (WAIT) @(posedge aclk);
    wr(11'h0A0, 8'h08);
    run[2] <= 1'b1;
    repeat (WAIT) @(posedge aclk);
    rd_chk(11'h0A0, 8'h08);
    wr(11'h0A0, 8'h08);
    // Only the four select bits hold a value
    wr(ad(2, lcis_pkg::OFS_EDGE), 8'hFF);
    rd_chk(ad(2, lcis_pkg::OFS_EDGE), 8'h1E);
    wr(ad(2, lcis_pkg::OFS_EDGE), 8'h00);
    // Upper channels and the extra channel, each in its own slot
    for (int c = 19; c <= 21; c++) begin
      drive(c, 6, 1'b1);
      drive(c, 6, 1'b0);
      rd_chk(ad(c, lcis_pkg::OFS_FLAGS), 8'h80);
      rd_chk(ad(c - 1, lcis_pkg::OFS_FLAGS), 8'h00);
      wr(ad(c, lcis_pkg::OFS_FLAGS), 8'h80);
    end
    rd_chk(11'h7E0, 8'h00);
    // Masked flag holds the interrupt low until unmasked
    wr(ad(0, lcis_pkg::OFS_MASK), 8'h80);
    drive(0, 6, 1'b1);
    drive(0, 6, 1'b0);
    rd_chk(11'h020, 8'h80);
    // Low byte lane off: the write-one must not clear
    wstrb <= 4'h0;
    wr(11'h020, 8'h80);
    wstrb <= 4'hF;
    rd_chk(11'h020, 8'h80);
    chk({31'h0, irq}, 32'h0);
    wr(ad(0, lcis_pkg::OFS_MASK), 8'h00);
    chk({31'h0, irq}, 32'h1);
    wr(11'h020, 8'h80);
    chk({31'h0, irq}, 32'h0);
    // Empty slot answers with a decode error and zero data
    rd(11'h5A0, d, r);
    chk({30'h0, r}, {30'h0, lcis_pkg::RESP_DEC});
    chk(d, 32'h00000000);
    wr(11'h5A0, 8'hFF);
    chk({30'h0, wresp}, {30'h0, lcis_pkg::RESP_DEC});
    wrap_up();
  end
endmodule
